// *** emb_pkg.sv ***
package emb_pkg;
    // idle level of all four bank selects, all inactive high
    localparam logic [3:0] EMB_SEL_IDLE_N = 4'hF;
    // bank that holds the boot image for port or flash boot
    localparam logic [1:0] EMB_BOOT_BANK  = 2'h1;
    // clock enable toward the sdram after reset
    localparam logic       EMB_CKE_RST    = 1'h1;
    // level of the sdram address-ten line outside sdram accesses
    localparam logic       EMB_A10_IDLE   = 1'h1;
    // clock rate in mhz and least refresh occupancy in ns
    localparam int         EMB_CLK_MHZ    = 100;
    localparam int         EMB_REF_NS     = 60;
    // least time rounds up to whole cycles
    localparam int         EMB_REF_CYC    =
        (EMB_REF_NS * EMB_CLK_MHZ + 999) / 1000;
    localparam logic [3:0] EMB_REF_LAST   = 4'(EMB_REF_CYC);
    // access sequencer states
    typedef enum logic [1:0] {
        EMB_S_IDLE,
        EMB_S_ADDR,
        EMB_S_WAIT
    } emb_seq_state_t;
endpackage

// *** emb_acc_if.sv ***
`timescale 1ns/1ps
interface emb_acc_if #(
    parameter int ADDR_W = 24
);
    logic              start;  // take a new access this cycle
    logic [ADDR_W-1:0] req_addr; // address offered with start
    logic              req_sdram; // offered access targets sdram
    logic              ack;    // acknowledge from the far side
    logic              busy;   // access in progress
    logic              done;   // one-cycle completion pulse
    logic [ADDR_W-1:0] addr;   // latched address of the access
    logic              sdram;  // latched sdram flag

    modport ctl (output start, req_addr, req_sdram, ack,
                 input  busy, done, addr, sdram);
    modport seq (input  start, req_addr, req_sdram, ack,
                 output busy, done, addr, sdram);
endinterface

// *** emb_acc_seq.sv ***
`timescale 1ns/1ps
module emb_acc_seq
    import emb_pkg::*;
#(
    parameter int ADDR_W = 24
) (
    // clock, reset, enable
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic ce,
    // access carrier
    emb_acc_if.seq    io
);
    emb_seq_state_t    state_reg;  // current phase
    emb_seq_state_t    state_next; // next phase
    logic [ADDR_W-1:0] addr_reg;   // latched address
    logic              sdram_reg;  // latched target kind
    logic              done_reg;   // completion pulse
    wire               take  = (state_reg == EMB_S_IDLE) && io.start;
    wire               finish = (state_reg == EMB_S_WAIT) && io.ack;

    // phase decode
    always_comb begin
        case (state_reg)
            EMB_S_IDLE: state_next = take ? EMB_S_ADDR : EMB_S_IDLE;
            EMB_S_ADDR: state_next = EMB_S_WAIT;
            // low acknowledge stretches the access
            EMB_S_WAIT: state_next = io.ack ? EMB_S_IDLE : EMB_S_WAIT;
            default:    state_next = EMB_S_IDLE;
        endcase
    end

    // phase and latched request
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= EMB_S_IDLE;
            addr_reg  <= '0;
            sdram_reg <= 1'h0;
            done_reg  <= 1'h0;
        end else if (ce) begin
            state_reg <= state_next;
            done_reg  <= finish;
            if (take) begin
                addr_reg  <= io.req_addr;
                sdram_reg <= io.req_sdram;
            end
        end
    end

    assign io.busy  = (state_reg != EMB_S_IDLE);
    assign io.done  = done_reg;
    assign io.addr  = addr_reg;
    assign io.sdram = sdram_reg;
endmodule

// *** emb_bank_sel.sv ***
`timescale 1ns/1ps
module emb_bank_sel
    import emb_pkg::*;
#(
    parameter int ADDR_W = 24
) (
    // clock, reset, enable
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              clk_en,
    // access request from the core
    input  wire logic              acc_req,
    input  wire logic [ADDR_W-1:0] acc_addr,
    input  wire logic              acc_sdram,
    input  wire logic              acc_cond_true,
    input  wire logic              ack,
    output logic                   acc_busy,
    output logic                   acc_done,
    output logic                   strobe_en,
    // refresh request and status
    input  wire logic              ref_req,
    output logic                   ref_busy,
    // configuration levels
    input  wire logic              boot_ext,
    input  wire logic              ms2_mode,
    input  wire logic              ms3_mode,
    input  wire logic              timer_mode,
    input  wire logic              sdram_pwrdn,
    // other functions of shared pins
    input  wire logic              flag2_out,
    input  wire logic              flag2_oe,
    input  wire logic              flag3_out,
    input  wire logic              flag3_oe,
    input  wire logic              timer_expired_out,
    // memory pins
    output logic [ADDR_W-1:0]      ext_addr,
    output logic [1:0]             bank_sel_n,
    output logic                   shared2_out,
    output logic                   shared2_oe,
    output logic                   shared3_out,
    output logic                   shared3_oe,
    output logic                   sdram_addr_ten_out,
    output logic                   sdram_clk_en_out,
    output logic                   sdram_clk_out0
);
    // upper two address bits pick the bank; a boot access always gets EMB_BOOT_BANK
    function automatic logic [1:0] addr_bank(logic [ADDR_W-1:0] a,
                                             logic boot);
        addr_bank = boot ? EMB_BOOT_BANK : a[ADDR_W-1:ADDR_W-2];
    endfunction

    // one-hot low select for a bank
    function automatic logic [3:0] bank_onehot_n(logic [1:0] b);
        bank_onehot_n = ~(4'h1 << b);
    endfunction

    logic [1:0]        rst_sync_reg;   // reset release chain
    wire               rst_n = rst_sync_reg[1];
    emb_acc_if #(.ADDR_W(ADDR_W)) acc ();

    logic [3:0]        sel_n_reg;      // all four selects, internal
    logic [ADDR_W-1:0] addr_reg;       // address pins
    logic              sh2_out_reg;    // shared pin two level
    logic              sh2_oe_reg;     // shared pin two drive
    logic              sh3_out_reg;    // shared pin three level
    logic              sh3_oe_reg;     // shared pin three drive
    logic              a10_reg;        // sdram address ten
    logic              cke_reg;        // sdram clock enable
    logic              sclk_reg;       // sdram clock toggle
    logic              busy_reg;       // access busy to core
    logic              strobe_reg;     // data strobes allowed
    logic              ref_pend_reg;   // refresh waiting
    logic [3:0]        ref_cnt_reg;    // refresh cycles remaining
    logic              ref_busy_reg;   // refresh running, pin copy

    // shared decode
    wire        ref_active = (ref_cnt_reg != 4'h0);
    wire        sd_acc     = acc.busy && acc.sdram;
    // sdram access waits out a running refresh; others do not
    wire        start_ok   = !(acc_sdram && ref_active);
    wire        ref_start  = ref_pend_reg && !ref_active && !sd_acc;
    // next count, shared by the counter and its registered busy copy
    wire [3:0]  ref_cnt_next = ref_start ? EMB_REF_LAST
        : (ref_active ? ref_cnt_reg - 4'h1 : ref_cnt_reg);
    wire [3:0]  sel_n_next = acc.busy
        ? bank_onehot_n(addr_bank(acc.addr, boot_ext))
        : EMB_SEL_IDLE_N;
    wire        a10_next   = sd_acc ? acc.addr[10] : EMB_A10_IDLE;
    // pin function chosen by configuration levels
    wire        sh2_o_next = ms2_mode ? sel_n_next[2] : flag2_out;
    wire        sh2_e_next = ms2_mode ? 1'h1 : flag2_oe;
    wire        sh3_alt    = timer_mode ? timer_expired_out : flag3_out;
    wire        sh3_o_next = ms3_mode ? sel_n_next[3] : sh3_alt;
    wire        sh3_e_next = ms3_mode || timer_mode || flag3_oe;

    assign acc.start     = acc_req && !acc.done && start_ok;
    assign acc.req_addr  = acc_addr;
    assign acc.req_sdram = acc_sdram;
    assign acc.ack       = ack;

    emb_acc_seq #(.ADDR_W(ADDR_W)) u_seq (
        .mclk (mclk),
        .rst_n(rst_n),
        .ce   (clk_en),
        .io   (acc)
    );

    // reset release through two flops
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) rst_sync_reg <= 2'h0;
        else        rst_sync_reg <= {rst_sync_reg[0], 1'h1};
    end

    // pins follow the sequencer; selects and address move together
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sel_n_reg   <= EMB_SEL_IDLE_N;
            addr_reg    <= '0;
            sh2_out_reg <= 1'h1;
            sh2_oe_reg  <= 1'h0;
            sh3_out_reg <= 1'h1;
            sh3_oe_reg  <= 1'h0;
            a10_reg     <= EMB_A10_IDLE;
        end else if (clk_en) begin
            sel_n_reg   <= sel_n_next;
            addr_reg    <= acc.addr;
            sh2_out_reg <= sh2_o_next;
            sh2_oe_reg  <= sh2_e_next;
            sh3_out_reg <= sh3_o_next;
            sh3_oe_reg  <= sh3_e_next;
            a10_reg     <= a10_next;
        end
    end

    // core status; the condition never gates the select
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg   <= 1'h0;
            strobe_reg <= 1'h0;
        end else if (clk_en) begin
            busy_reg   <= acc.busy;
            strobe_reg <= acc.busy && acc_cond_true;
        end
    end

    // refresh: request sticks, set wins over the start clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ref_pend_reg <= 1'h0;
            ref_cnt_reg  <= 4'h0;
            ref_busy_reg <= 1'h0;
        end else if (clk_en) begin
            ref_pend_reg <= ref_req || (ref_pend_reg && !ref_start);
            ref_cnt_reg  <= ref_cnt_next;
            // flop copy keeps the pin glitch free, same timing as count
            ref_busy_reg <= (ref_cnt_next != 4'h0);
        end
    end

    // sdram clock, low out of reset; clock enable high from reset, low while sdram_pwrdn
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cke_reg  <= EMB_CKE_RST;
            sclk_reg <= 1'h0;
        end else if (clk_en) begin
            cke_reg  <= !sdram_pwrdn;
            sclk_reg <= !sclk_reg;
        end
    end

    assign ext_addr           = addr_reg;
    assign bank_sel_n         = sel_n_reg[1:0];
    assign shared2_out        = sh2_out_reg;
    assign shared2_oe         = sh2_oe_reg;
    assign shared3_out        = sh3_out_reg;
    assign shared3_oe         = sh3_oe_reg;
    assign sdram_addr_ten_out = a10_reg;
    assign sdram_clk_en_out   = cke_reg;
    assign sdram_clk_out0     = sclk_reg;
    assign acc_busy           = busy_reg;
    assign acc_done           = acc.done;
    assign strobe_en          = strobe_reg;
    assign ref_busy           = ref_busy_reg;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n || !clk_en);

    a_sel_idle_high: assert property (
        !acc.busy |=> sel_n_reg == EMB_SEL_IDLE_N)
        else $error("bank select active with no access");
    a_sel_one_low: assert property (
        acc.busy |=> $countones(~sel_n_reg) == 1)
        else $error("not exactly one bank selected");
    a_sel_decode: assert property (
        acc.busy && !boot_ext |=>
            !sel_n_reg[$past(acc.addr[ADDR_W-1:ADDR_W-2])])
        else $error("bank select not from upper address");
    a_boot_bank: assert property (
        acc.busy && boot_ext |=> sel_n_reg == 4'hD)
        else $error("boot access not on bank one");
    a_cond_ignored: assert property (
        acc.busy && !acc_cond_true |=> !strobe_reg && sel_n_reg != 4'hF)
        else $error("false condition dropped the select");
    a_a10_idle: assert property (
        !sd_acc |=> a10_reg == EMB_A10_IDLE)
        else $error("address ten driven outside sdram access");
    a_ref_overlap: assert property (
        ref_pend_reg && !ref_active && acc.busy && !acc.sdram
            |=> ref_cnt_reg == EMB_REF_LAST)
        else $error("refresh blocked by non-sdram access");
    a_ack_hold: assert property (
        (acc.busy && !ack) [*2] |=> acc.busy && !acc.done)
        else $error("access completed with acknowledge low");
    a_ms2_pin: assert property (
        !ms2_mode |=> shared2_out == $past(flag2_out))
        else $error("shared pin two left flag function");
    a_cke_high: assert property (
        !sdram_pwrdn |=> cke_reg)
        else $error("clock enable dropped");

    c_sdram_acc: cover property (acc.start && acc_sdram ##[1:20] acc.done);
    c_wait_state: cover property ((acc.busy && !ack) [*3] ##2 acc.done);
    c_ref_overlap: cover property (ref_start && acc.busy && !acc.sdram);
endmodule

// *** emb_mem_model.sv ***
`timescale 1ns/1ps
module emb_mem_model (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // selects seen on the pins
    input  wire logic [1:0] bank_sel_n,
    input  wire logic       shared2_out,
    input  wire logic       shared2_oe,
    input  wire logic       shared3_out,
    input  wire logic       shared3_oe,
    // wait states this memory asks for
    input  wire logic [3:0] wait_cyc,
    // acknowledge back to the port
    output logic            ack
);
    logic       sel_hit; // some bank selected
    logic [3:0] cnt_reg; // wait states served so far
    // a low shared pin looks like a select, as a real memory would see it
    assign sel_hit = ~&bank_sel_n | (shared2_oe & ~shared2_out)
                   | (shared3_oe & ~shared3_out);
    // drops at once on select when wait_cyc is nonzero; pull-up keeps it high when idle
    assign ack = ~(sel_hit && cnt_reg != wait_cyc);
    // count served wait states while the select stands
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 4'h0;
        end else if (!sel_hit) begin
            cnt_reg <= 4'h0;
        end else if (cnt_reg != wait_cyc) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule

// *** emb_bank_sel_tb_top.sv ***
`timescale 1ns/1ps
`define CHECK(g, w) begin comparisons++; if ((g) !== (w)) begin errors++; \
    $display("unexpected at %0t: got %0h want %0h", $time, g, w); end end
module emb_bank_sel_tb_top;
    import emb_pkg::*;
    // stimulus and observed pins
    logic        mclk, rst_b, acc_req, acc_sdram, acc_cond_true, ref_req;
    logic        boot_ext, ms2_mode, ms3_mode, timer_mode, sdram_pwrdn;
    logic        flag2_out, flag2_oe, flag3_out, flag3_oe, tmr_out;
    logic [23:0] acc_addr, ext_addr;
    logic [3:0]  wait_cyc;
    logic [1:0]  bank_sel_n;
    logic        ack, acc_busy, acc_done, strobe_en, ref_busy;
    logic        s2_out, s2_oe, s3_out, s3_oe, a10, cke, sclk;
    int          errors, comparisons;

    emb_bank_sel #(.ADDR_W(24)) dut_u (.mclk(mclk), .rst_b(rst_b),
        .clk_en(1'h1), .acc_req(acc_req), .acc_addr(acc_addr),
        .acc_sdram(acc_sdram), .acc_cond_true(acc_cond_true), .ack(ack),
        .acc_busy(acc_busy), .acc_done(acc_done), .strobe_en(strobe_en),
        .ref_req(ref_req), .ref_busy(ref_busy), .boot_ext(boot_ext),
        .ms2_mode(ms2_mode), .ms3_mode(ms3_mode), .timer_mode(timer_mode),
        .sdram_pwrdn(sdram_pwrdn), .flag2_out(flag2_out),
        .flag2_oe(flag2_oe), .flag3_out(flag3_out), .flag3_oe(flag3_oe),
        .timer_expired_out(tmr_out), .ext_addr(ext_addr),
        .bank_sel_n(bank_sel_n), .shared2_out(s2_out), .shared2_oe(s2_oe),
        .shared3_out(s3_out), .shared3_oe(s3_oe),
        .sdram_addr_ten_out(a10), .sdram_clk_en_out(cke),
        .sdram_clk_out0(sclk));

    emb_mem_model mem_u (.mclk(mclk), .rst_b(rst_b), .bank_sel_n(bank_sel_n),
        .shared2_out(s2_out), .shared2_oe(s2_oe), .shared3_out(s3_out),
        .shared3_oe(s3_oe), .wait_cyc(wait_cyc), .ack(ack));

    // free-running 100 mhz clock
    always #5 mclk = ~mclk;

    // verdict and end of run
    task automatic wrap_up();
        if (errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // one access, judged at the pins; bank from the top two address bits, or the boot bank under boot_ext
    task automatic t_acc(input logic [23:0] a, input logic sd,
                         input logic cnd, input logic [3:0] w);
        int         n;
        logic       seen;
        logic [1:0] bk;
        bk = boot_ext ? EMB_BOOT_BANK : a[23:22];
        seen = 1'b0;
        n = 0;
        @(negedge mclk);
        {acc_addr, acc_sdram, acc_cond_true, wait_cyc} = {a, sd, cnd, w};
        acc_req = 1'b1;
        while (acc_done !== 1'b1) begin
            @(negedge mclk);
            n++;
            if (acc_busy === 1'b1 && !seen) begin
                seen = 1'b1;
                `CHECK(bank_sel_n, ~(2'h1 << bk))
                `CHECK(ext_addr, a)
                `CHECK(a10, sd ? a[10] : EMB_A10_IDLE)
                `CHECK(strobe_en, cnd)
                if (ms2_mode) `CHECK(s2_out, bk != 2'h2)
                if (!ms2_mode) `CHECK(s2_out, flag2_out)
                if (ms3_mode) `CHECK(s3_out, bk != 2'h3)
                if (!ms3_mode) `CHECK(s3_out, timer_mode ? tmr_out : flag3_out)
            end
            if (n > 60) begin
                errors++;
                wrap_up();
            end
        end
        `CHECK(n, 3 + w)
        `CHECK(seen, 1'b1)
        acc_req = 1'b0;
        @(negedge mclk);
        `CHECK(bank_sel_n, EMB_SEL_IDLE_N[1:0])
    endtask

    // refresh launched beside a slow non-sdram access
    task automatic t_ref();
        int   rb;
        logic ov;
        rb = 0;
        ov = 1'b0;
        @(negedge mclk);
        {acc_addr, acc_sdram, acc_cond_true} = {24'h400000, 1'b0, 1'b1};
        wait_cyc = 4'hC;
        acc_req = 1'b1;
        ref_req = 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(negedge mclk);
            ref_req = 1'b0;
            if (ref_busy === 1'b1) rb++;
            if (ref_busy === 1'b1 && acc_busy === 1'b1) ov = 1'b1;
            if (acc_done === 1'b1) acc_req = 1'b0;
        end
        `CHECK(rb, EMB_REF_CYC)
        `CHECK(ov, 1'b1)
        `CHECK(acc_req, 1'b0)
    endtask

    // shared pins in their other functions, clock enable power-down
    task automatic t_modes();
        logic ck;
        // timer high and flag low so pin three shows which one it carries
        {ms2_mode, ms3_mode, flag2_out, timer_mode, tmr_out, flag3_out} =
            6'h06;
        repeat (2) @(negedge mclk);
        `CHECK({s2_out, s2_oe, s3_out, s3_oe}, 4'h3)
        t_acc(24'h800010, 1'b0, 1'b1, 4'h0);
        `CHECK({s3_out, s3_oe}, 2'h3)
        {ms2_mode, ms3_mode, flag2_out, timer_mode} = 4'hE;
        sdram_pwrdn = 1'b1;
        repeat (2) @(negedge mclk);
        `CHECK(cke, 1'b0)
        sdram_pwrdn = 1'b0;
        ck = sclk;
        @(negedge mclk);
        `CHECK(sclk, !ck)
        @(negedge mclk);
        `CHECK(cke, 1'b1)
    endtask

    // main sequence
    initial begin
        {mclk, rst_b, acc_req, acc_sdram, acc_cond_true, ref_req} = 6'h0;
        {boot_ext, timer_mode, sdram_pwrdn, flag3_out, tmr_out} = 5'h02;
        {ms2_mode, ms3_mode, flag2_out, flag2_oe, flag3_oe} = 5'h1D;
        {acc_addr, wait_cyc, errors, comparisons} = '0;
        repeat (3) @(negedge mclk);
        `CHECK({cke, a10, bank_sel_n}, 4'hF)
        rst_b = 1'b1;
        repeat (5) @(negedge mclk);
        `CHECK(cke, 1'b1)
        for (int b = 0; b < 4; b++) begin
            t_acc({2'(b), 22'h000155}, 1'b0, 1'b1, 4'h0);
        end
        t_acc(24'h400020, 1'b0, 1'b1, 4'h3);
        t_acc(24'h000030, 1'b0, 1'b1, 4'h7);
        t_acc(24'h000040, 1'b0, 1'b0, 4'h0);
        t_acc(24'h000000, 1'b1, 1'b1, 4'h0);
        t_acc(24'h000400, 1'b1, 1'b1, 4'h1);
        boot_ext = 1'b1;
        t_acc(24'hC00050, 1'b0, 1'b1, 4'h0);
        boot_ext = 1'b0;
        t_ref();
        t_modes();
        wrap_up();
    end
endmodule
